// *** sms_command_gatekeeper.sv ***
// text command gatekeeper: password, matching, config window, replies, indicators
`timescale 1ns/1ns
`default_nettype none
`include "sms_gate_map.svh"

module sms_command_gatekeeper import sms_gate_pkg::*; #(
  parameter longint unsigned WINDOW_CYCLES = 64'(`CFG_WINDOW_MIN) * 64'd60 * 64'(`CLK_HZ),
  parameter int unsigned TICK_CYCLES = `LED_TICK_MS * (`CLK_HZ / 1000)
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq,
  input wire logic [7:0] msgChar,
  input wire logic msgCharValid,
  input wire logic msgEnd,
  input wire logic senderKnown,
  input wire logic nvmValid,
  input wire logic [2:0] nvmLoadData,
  output logic nvmWrite,
  output logic [2:0] nvmData,
  output logic replyValid,
  output logic [2:0] replyCode,
  output logic [2:0] replyCmd,
  output logic [1:0] replyArg,
  output logic ownerStore,
  input wire logic startupOk,
  input wire logic netRegistered,
  input wire logic simPinRequired,
  output logic powerLed,
  output logic functionLed,
  output logic networkLed
);

  // ----------------------------------------------------------------
  // command table
  // ----------------------------------------------------------------
  localparam logic [95:0] CMD_TXT [`CMD_COUNT] = '{
    96'(`CMD_TXT_OWNER), 96'(`CMD_TXT_ERRON), 96'(`CMD_TXT_ERROFF), 96'(`CMD_TXT_REPON),
    96'(`CMD_TXT_REPOFF), 96'(`CMD_TXT_ERRQ), 96'(`CMD_TXT_REPQ), 96'(`CMD_TXT_STATUS)};
  localparam logic [47:0] CMD_LEN = `CMD_LENS;

  function automatic logic [5:0] cmdLen(input int i);
    cmdLen = CMD_LEN[6 * (`CMD_COUNT - 1 - i) +: 6];
  endfunction

  function automatic logic [7:0] cmdChar(input int i, input logic [5:0] pos);
    int idx;
    idx = int'(cmdLen(i)) - 1 - int'(pos);
    cmdChar = CMD_TXT[i][8 * idx +: 8];
  endfunction

  function automatic cmdClass_t cmdClass(input logic [2:0] i);
    if (i <= 3'd4) begin
      cmdClass = CLS_CONFIG;
    end else if (i == 3'd7) begin
      cmdClass = CLS_CTRL;
    end else begin
      cmdClass = CLS_INFO;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic replyOn_r, errorOn_r, secListOn_r, loaded_r;
  logic [3:0] pwLen_r;
  logic [63:0] pw_r;
  logic [`EVT_COUNT-1:0] status_r, mask_r, evt;
  logic [5:0] msgLen_r;
  logic pwOk_r;
  logic [`CMD_COUNT-1:0] match_r, hit;
  logic [39:0] winCnt_r;
  logic windowOpen;
  logic [7:0] upChar;
  logic [5:0] cmdChars;
  logic overlong, pwAccepted, anyHit;
  logic [2:0] hitIdx;
  logic wbReq, wbWrite, wbRead;
  logic [1:0] syncOk_r, syncReg_r, syncPin_r;

  assign wbReq = cyc_i & stb_i & ~ack_o;
  assign wbWrite = wbReq & we_i;
  assign wbRead = wbReq & ~we_i;
  assign windowOpen = winCnt_r < 40'(WINDOW_CYCLES);

  // ----------------------------------------------------------------
  // message scanning
  // ----------------------------------------------------------------
  always_comb begin
    upChar = msgChar;
    if (msgChar >= 8'h61 && msgChar <= 8'h7A) begin
      upChar = msgChar - 8'h20;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      msgLen_r <= 6'h00;
      pwOk_r <= 1'b1;
      match_r <= '1;
    end else if (msgEnd) begin
      msgLen_r <= 6'h00;
      pwOk_r <= 1'b1;
      match_r <= '1;
    end else if (msgCharValid) begin
      if (msgLen_r != 6'h3F) begin
        msgLen_r <= msgLen_r + 6'h01;
      end
      if (msgLen_r < {2'b00, pwLen_r}) begin
        if (msgChar != pw_r[8 * msgLen_r[2:0] +: 8]) begin
          pwOk_r <= 1'b0;
        end
      end else begin
        for (int i = 0; i < `CMD_COUNT; i++) begin
          if (msgLen_r - {2'b00, pwLen_r} >= cmdLen(i) ||
              upChar != cmdChar(i, msgLen_r - {2'b00, pwLen_r})) begin
            match_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_comb begin
    cmdChars = msgLen_r - {2'b00, pwLen_r};
    overlong = msgLen_r > `MAX_CMD_CHARS;
    pwAccepted = pwOk_r && msgLen_r >= {2'b00, pwLen_r};
    hitIdx = 3'd0;
    anyHit = 1'b0;
    for (int i = 0; i < `CMD_COUNT; i++) begin
      hit[i] = match_r[i] && cmdChars == cmdLen(i);
    end
    for (int i = `CMD_COUNT - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hitIdx = 3'(i);
        anyHit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration window
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      winCnt_r <= 40'h0000000000;
    end else if (msgEnd && !overlong && pwAccepted && anyHit &&
                 cmdClass(hitIdx) == CLS_CONFIG && windowOpen) begin
      winCnt_r <= 40'h0000000000;
    end else if (windowOpen) begin
      winCnt_r <= winCnt_r + 40'h0000000001;
    end
  end

  // ----------------------------------------------------------------
  // command execution, settings and replies
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      replyOn_r <= `DEF_REPLY_ON;
      errorOn_r <= `DEF_ERROR_ON;
      secListOn_r <= `DEF_SECLIST_ON;
      loaded_r <= 1'b0;
      nvmWrite <= 1'b0;
      nvmData <= 3'h0;
      replyValid <= 1'b0;
      replyCode <= 3'h0;
      replyCmd <= 3'h0;
      replyArg <= 2'h0;
      ownerStore <= 1'b0;
      evt <= '0;
    end else begin
      nvmWrite <= 1'b0;
      replyValid <= 1'b0;
      ownerStore <= 1'b0;
      evt <= '0;
      loaded_r <= 1'b1;
      if (!loaded_r && nvmValid) begin
        {secListOn_r, errorOn_r, replyOn_r} <= nvmLoadData;
      end else if (wbWrite && adr_i == `REG_CTRL && sel_i[0]) begin
        replyOn_r <= dat_i[`CTRL_REPLY_BIT];
        errorOn_r <= dat_i[`CTRL_ERROR_BIT];
        secListOn_r <= dat_i[`CTRL_SECLIST_BIT];
        nvmWrite <= 1'b1;
        nvmData <= {dat_i[`CTRL_SECLIST_BIT], dat_i[`CTRL_ERROR_BIT], dat_i[`CTRL_REPLY_BIT]};
      end else if (msgEnd) begin
        replyCmd <= hitIdx;
        replyArg <= 2'h0;
        if (overlong) begin
          evt[`EVT_OVERLONG_BIT] <= 1'b1;
        end else if (!pwAccepted) begin
          replyValid <= 1'b0;
        end else if (!anyHit) begin
          evt[`EVT_UNKNOWN_BIT] <= 1'b1;
          replyValid <= errorOn_r;
          replyCode <= RPY_UNKNOWN;
        end else if (cmdClass(hitIdx) == CLS_CONFIG && !windowOpen) begin
          evt[`EVT_EXPIRED_BIT] <= 1'b1;
          replyValid <= errorOn_r;
          replyCode <= RPY_EXPIRED;
        end else begin
          evt[`EVT_DONE_BIT] <= 1'b1;
          replyValid <= replyOn_r;
          replyCode <= RPY_OK;
          nvmWrite <= cmdClass(hitIdx) == CLS_CONFIG;
          nvmData <= {secListOn_r, errorOn_r, replyOn_r};
          case (hitIdx)
            3'd0: begin
              if (senderKnown) begin
                ownerStore <= 1'b1;
                secListOn_r <= 1'b1;
                evt[`EVT_OWNER_BIT] <= 1'b1;
                nvmData <= {1'b1, errorOn_r, replyOn_r};
              end else begin
                nvmWrite <= 1'b0;
              end
            end
            3'd1: begin
              errorOn_r <= 1'b1;
              nvmData <= {secListOn_r, 1'b1, replyOn_r};
            end
            3'd2: begin
              errorOn_r <= 1'b0;
              nvmData <= {secListOn_r, 1'b0, replyOn_r};
            end
            3'd3: begin
              replyOn_r <= 1'b1;
              nvmData <= {secListOn_r, errorOn_r, 1'b1};
            end
            3'd4: begin
              replyOn_r <= 1'b0;
              nvmData <= {secListOn_r, errorOn_r, 1'b0};
            end
            3'd5: begin
              replyCode <= RPY_QUERY;
              replyArg <= {1'b0, ~errorOn_r};
            end
            3'd6: begin
              replyCode <= RPY_QUERY;
              replyArg <= {1'b0, ~replyOn_r};
            end
            3'd7: begin
              replyCode <= RPY_STATUS;
              replyArg <= {secListOn_r, windowOpen};
            end
            default: begin
              replyCode <= RPY_OK;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wbReq;
      dat_o <= 32'h00000000;
      if (wbRead) begin
        case (adr_i)
          `REG_CTRL: dat_o <= {29'h0, secListOn_r, errorOn_r, replyOn_r};
          `REG_STATUS: dat_o <= 32'(status_r);
          `REG_MASK: dat_o <= 32'(mask_r);
          `REG_PWLEN: dat_o <= {28'h0, pwLen_r};
          `REG_PW0: dat_o <= pw_r[31:0];
          `REG_PW1: dat_o <= pw_r[63:32];
          `REG_STATE: dat_o <= {28'h0, loaded_r, secListOn_r, 1'b0, windowOpen};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= '0;
      pwLen_r <= 4'h0;
      pw_r <= 64'h0000000000000000;
    end else if (wbWrite) begin
      case (adr_i)
        `REG_MASK: begin
          if (sel_i[0]) begin
            mask_r <= dat_i[`EVT_COUNT-1:0];
          end
        end
        `REG_PWLEN: begin
          if (sel_i[0]) begin
            pwLen_r <= dat_i[3:0] > `PW_MAX_LEN ? `PW_MAX_LEN : dat_i[3:0];
          end
        end
        `REG_PW0, `REG_PW1: begin
          for (int b = 0; b < 4; b++) begin
            if (sel_i[b]) begin
              pw_r[32 * int'(adr_i == `REG_PW1) + 8 * b +: 8] <= dat_i[8 * b +: 8];
            end
          end
        end
        default: begin
          mask_r <= mask_r;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= '0;
      irq <= 1'b0;
    end else begin
      // new events win over the read-clear
      if (wbRead && adr_i == `REG_STATUS) begin
        status_r <= evt;
      end else begin
        status_r <= status_r | evt;
      end
      irq <= |(status_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  logic [23:0] tickCnt_r;
  logic tick;
  logic [3:0] subCnt_r;
  logic [1:0] periodCnt_r, bootBlinks_r;
  logic bootDone_r;

  assign tick = tickCnt_r == 24'(TICK_CYCLES - 1);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncOk_r <= 2'b00;
      syncReg_r <= 2'b00;
      syncPin_r <= 2'b00;
    end else begin
      syncOk_r <= {syncOk_r[0], startupOk};
      syncReg_r <= {syncReg_r[0], netRegistered};
      syncPin_r <= {syncPin_r[0], simPinRequired};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt_r <= 24'h000000;
      subCnt_r <= 4'h0;
      periodCnt_r <= 2'h0;
      bootBlinks_r <= 2'h0;
      bootDone_r <= 1'b0;
    end else begin
      tickCnt_r <= tick ? 24'h000000 : tickCnt_r + 24'h000001;
      if (tick) begin
        subCnt_r <= subCnt_r == `BLINK_TICKS - 4'h1 ? 4'h0 : subCnt_r + 4'h1;
        if (subCnt_r == `BLINK_TICKS - 4'h1) begin
          periodCnt_r <= periodCnt_r == `REG_BLINK_PERIODS - 2'h1 ? 2'h0 : periodCnt_r + 2'h1;
          if (!bootDone_r) begin
            bootBlinks_r <= bootBlinks_r + 2'h1;
            bootDone_r <= bootBlinks_r == `BOOT_BLINKS - 2'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      powerLed <= 1'b0;
      functionLed <= 1'b0;
      networkLed <= 1'b0;
    end else if (!bootDone_r) begin
      powerLed <= subCnt_r < `BLINK_ON_TICKS;
      functionLed <= subCnt_r < `BLINK_ON_TICKS;
      networkLed <= 1'b0;
    end else begin
      powerLed <= syncOk_r[1];
      functionLed <= 1'b0;
      networkLed <= subCnt_r == 4'h0 &&
                    (syncPin_r[1] || !syncReg_r[1] || periodCnt_r == 2'h0);
    end
  end

endmodule
`default_nettype wire

// *** sms_gate_map.svh ***
// offsets, field positions, reset values and timing counts of the command gatekeeper
// Notes on behaviour
// - configured password must prefix the command text
// - command names match regardless of letter case
// - configuration only within 30-minute restartable window
// - late configuration rejected; expired reply if enabled
// - accepted configuration values written to non-volatile storage
// - settings start from factory defaults, then load from storage if nvmValid just after reset
// - information commands anytime; trailing question mark queries
// - query lists values, default first, active marked
// - control commands run regardless of window
// - reply after each command unless replies disabled
// - unknown command reply only while error replies on
// - commands over 30 characters dropped silently
// - boot: power and function blink three times
// - network blink 1 s searching, 3 s registered
// - network blinks every second while PIN required
// - claim owner stores sender, enables security list
// - hidden sender number is never stored
`ifndef SMS_GATE_MAP_SVH
`define SMS_GATE_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_PWLEN 8'h0C
`define REG_PW0 8'h10
`define REG_PW1 8'h14
`define REG_STATE 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_REPLY_BIT 0
`define CTRL_ERROR_BIT 1
`define CTRL_SECLIST_BIT 2
`define EVT_DONE_BIT 0
`define EVT_EXPIRED_BIT 1
`define EVT_UNKNOWN_BIT 2
`define EVT_OVERLONG_BIT 3
`define EVT_OWNER_BIT 4
`define EVT_COUNT 5
`define PW_MAX_LEN 4'h8

// ----------------------------------------------------------------
// factory defaults
// ----------------------------------------------------------------
`define DEF_REPLY_ON 1'b1
`define DEF_ERROR_ON 1'b1
`define DEF_SECLIST_ON 1'b0

// ----------------------------------------------------------------
// command texts (upper case), lengths and count
// ----------------------------------------------------------------
`define CMD_COUNT 8
`define CMD_TXT_OWNER 80'h4D414B454D45424F5353
`define CMD_TXT_ERRON "ERROR=ON"
`define CMD_TXT_ERROFF "ERROR=OFF"
`define CMD_TXT_REPON "REPLY=ON"
`define CMD_TXT_REPOFF "REPLY=OFF"
`define CMD_TXT_ERRQ "ERROR?"
`define CMD_TXT_REPQ "REPLY?"
`define CMD_TXT_STATUS "STATUS"
`define CMD_LENS {6'd10, 6'd8, 6'd9, 6'd8, 6'd9, 6'd6, 6'd6, 6'd6}
`define MAX_CMD_CHARS 6'd30

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 100000000
`define CFG_WINDOW_MIN 30
`define LED_TICK_MS 100
`define BLINK_TICKS 4'd10
`define BLINK_ON_TICKS 4'd5
`define BOOT_BLINKS 2'd3
`define REG_BLINK_PERIODS 2'd3

`endif

// *** sms_gate_pkg.sv ***
// types shared by the command gatekeeper
package sms_gate_pkg;

  typedef enum logic [1:0] {
    CLS_CONFIG,
    CLS_INFO,
    CLS_CTRL
  } cmdClass_t;

  typedef enum logic [2:0] {
    RPY_OK,
    RPY_QUERY,
    RPY_STATUS,
    RPY_EXPIRED,
    RPY_UNKNOWN
  } replyCode_t;

endpackage

// *** sms_command_gatekeeper_properties.sv ***
// concurrent checks on the gatekeeper ports
`timescale 1ns/1ns
`default_nettype none
module sms_command_gatekeeper_properties import sms_gate_pkg::*; #(
  parameter longint unsigned WINDOW_CYCLES = 200,
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic msgCharValid,
  input wire logic msgEnd,
  input wire logic senderKnown,
  input wire logic nvmWrite,
  input wire logic [2:0] nvmData,
  input wire logic replyValid,
  input wire logic [2:0] replyCode,
  input wire logic [1:0] replyArg,
  input wire logic ownerStore,
  input wire logic powerLed,
  input wire logic functionLed,
  input wire logic networkLed
);
  localparam int unsigned BOOT_END = 30 * TICK_CYCLES + 8;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // ----------
  // helper counters
  // ----------
  logic [5:0] charCnt;
  logic endQ;
  longint unsigned winCnt;
  int unsigned bootCnt, netGap;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) charCnt <= 6'h00;
    else if (msgEnd) charCnt <= 6'h00;
    else if (msgCharValid && charCnt != 6'h3F) charCnt <= charCnt + 6'h01;
  end
  // lags the real window by a cycle, hence the slack below
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      endQ <= 1'b0;
      winCnt <= 0;
    end else begin
      endQ <= msgEnd;
      winCnt <= (nvmWrite && endQ) ? 0 : winCnt + 1;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) bootCnt <= 0;
    else if (bootCnt < BOOT_END) bootCnt <= bootCnt + 1;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) netGap <= 0;
    else if ($rose(networkLed)) netGap <= 1;
    else if (netGap != 0) netGap <= netGap + 1;
  end
  // ----------
  // properties
  // ----------
  property p_replyCause;
    replyValid |-> $past(msgEnd);
  endproperty
  a_replyCause: assert property (p_replyCause)
    else $error("reply without message end");
  property p_ownerKnown;
    ownerStore |-> $past(msgEnd) && $past(senderKnown);
  endproperty
  a_ownerKnown: assert property (p_ownerKnown)
    else $error("owner stored for hidden sender");
  property p_ownerSaved;
    ownerStore |-> nvmWrite && nvmData[2];
  endproperty
  a_ownerSaved: assert property (p_ownerSaved)
    else $error("owner claim not saved with list on");
  property p_expiredInert;
    replyValid && replyCode == RPY_EXPIRED |-> !nvmWrite && !ownerStore;
  endproperty
  a_expiredInert: assert property (p_expiredInert)
    else $error("expired command changed settings");
  property p_windowLate;
    replyValid && (replyCode == RPY_EXPIRED || (replyCode == RPY_STATUS && !replyArg[0]))
      |-> winCnt + 4 >= WINDOW_CYCLES;
  endproperty
  a_windowLate: assert property (p_windowLate)
    else $error("window closed too early");
  property p_overlong;
    msgEnd && charCnt > 6'h1E |=> !replyValid && !nvmWrite && !ownerStore;
  endproperty
  a_overlong: assert property (p_overlong)
    else $error("long message not dropped");
  property p_funcPower;
    functionLed |-> powerLed;
  endproperty
  a_funcPower: assert property (p_funcPower)
    else $error("function lit without power");
  property p_funcOff;
    bootCnt == BOOT_END |-> !functionLed;
  endproperty
  a_funcOff: assert property (p_funcOff)
    else $error("function lit after boot");
  property p_netGap;
    $rose(networkLed) && netGap != 0 |-> netGap >= 10 * TICK_CYCLES;
  endproperty
  a_netGap: assert property (p_netGap)
    else $error("network blinks too fast");
endmodule
bind sms_command_gatekeeper sms_command_gatekeeper_properties #(
  .WINDOW_CYCLES(WINDOW_CYCLES), .TICK_CYCLES(TICK_CYCLES)) i_props (
  .clock(clock), .arst_n(arst_n), .msgCharValid(msgCharValid), .msgEnd(msgEnd),
  .senderKnown(senderKnown), .nvmWrite(nvmWrite), .nvmData(nvmData),
  .replyValid(replyValid), .replyCode(replyCode), .replyArg(replyArg),
  .ownerStore(ownerStore), .powerLed(powerLed), .functionLed(functionLed),
  .networkLed(networkLed));
`default_nettype wire

// *** sms_phone_model.sv ***
// remote phone user sending text messages
`timescale 1ns/1ns
`default_nettype none
module sms_phone_model (
  input wire logic clock,
  output logic [7:0] msgChar,
  output logic msgCharValid,
  output logic msgEnd,
  output logic senderKnown
);
  initial begin
    msgChar = 8'h00;
    msgCharValid = 1'b0;
    msgEnd = 1'b0;
    senderKnown = 1'b1;
  end
  // called just after an edge; one character a cycle, then the end pulse
  task automatic send(input string s, input logic known);
    for (int i = 0; i < s.len(); i++) begin
      msgChar <= s[i];
      msgCharValid <= 1'b1;
      senderKnown <= known;
      @(posedge clock);
    end
    msgCharValid <= 1'b0;
    msgChar <= ~msgChar;
    msgEnd <= 1'b1;
    @(posedge clock);
    msgEnd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sms_command_gatekeeper_bench.sv ***
// self-checking bench of the command gatekeeper
`timescale 1ns/1ns
`default_nettype none
`include "sms_gate_map.svh"
module sms_command_gatekeeper_bench import sms_gate_pkg::*; ;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic cyc_i, stb_i, we_i, irq, ack_o, nvmValid, nvmWrite, replyValid, ownerStore;
  logic startupOk, netRegistered, simPinRequired, powerLed, functionLed, networkLed;
  logic msgCharValid, msgEnd, senderKnown;
  logic [7:0] adr_i, msgChar;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [2:0] nvmLoadData, nvmData, replyCode, replyCmd;
  logic [1:0] replyArg;
  int fails = 0;
  int check_count = 0;
  string s30, ownerLow;
  always #5 clock = ~clock;
  sms_command_gatekeeper #(.WINDOW_CYCLES(2000), .TICK_CYCLES(2)) i_dut (
    .clock(clock), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq(irq),
    .msgChar(msgChar), .msgCharValid(msgCharValid), .msgEnd(msgEnd),
    .senderKnown(senderKnown), .nvmValid(nvmValid), .nvmLoadData(nvmLoadData),
    .nvmWrite(nvmWrite), .nvmData(nvmData), .replyValid(replyValid),
    .replyCode(replyCode), .replyCmd(replyCmd), .replyArg(replyArg),
    .ownerStore(ownerStore), .startupOk(startupOk), .netRegistered(netRegistered),
    .simPinRequired(simPinRequired), .powerLed(powerLed), .functionLed(functionLed),
    .networkLed(networkLed));
  sms_phone_model i_phone (.clock(clock), .msgChar(msgChar), .msgCharValid(msgCharValid),
    .msgEnd(msgEnd), .senderKnown(senderKnown));
  // ----------
  // shared tasks
  // ----------
  task automatic summarize();
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    if (ack_o !== 1'b1) begin
      fails++;
      summarize();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp(q, e);
  endtask
  task automatic chk(input string s, input logic k, input logic v, input logic [2:0] c,
      input logic [2:0] m, input logic [1:0] g, input logic o, input logic w);
    i_phone.send(s, k);
    @(posedge clock);
    cmp(32'(replyValid), 32'(v));
    cmp(32'(ownerStore), 32'(o));
    cmp(32'(nvmWrite), 32'(w));
    if (v) cmp({27'h0, replyCode, replyArg}, {27'h0, c, g});
    if (v && c != RPY_UNKNOWN) cmp(32'(replyCmd), 32'(m));
  endtask
  task automatic cnt(input int n, output int f, output int w);
    logic pf, pw;
    f = 0;
    w = 0;
    pf = functionLed;
    pw = networkLed;
    repeat (n) begin
      @(posedge clock);
      f += int'(functionLed && !pf);
      w += int'(networkLed && !pw);
      pf = functionLed;
      pw = networkLed;
    end
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_leds();
    int f, w;
    cnt(100, f, w);
    cmp(f, 3);
    cmp(32'(powerLed), 1);
    cnt(200, f, w);
    cmp(32'(w > 8 && w < 12), 1);
    netRegistered <= 1'b1;
    simPinRequired <= 1'b1;
    cnt(200, f, w);
    cmp(32'(w > 8 && w < 12), 1);
    simPinRequired <= 1'b0;
    cnt(240, f, w);
    cmp(32'(w > 2 && w < 6), 1);
    cmp(f, 0);
    startupOk <= 1'b0;
    repeat (4) @(posedge clock);
    cmp(32'(powerLed), 0);
    startupOk <= 1'b1;
    repeat (4) @(posedge clock);
    cmp(32'(powerLed), 1);
  endtask
  task automatic t_regs();
    rd(`REG_CTRL, 32'h3);
    wb(1'b0, `REG_STATE, 32'h0);
    cmp(q & 32'h5, 32'h1);
    rd(8'h1C, 32'h0);
    wb(1'b1, `REG_MASK, 32'h1);
    chk("status", 1, 1, RPY_STATUS, 7, 1, 0, 0);
    repeat (3) @(posedge clock);
    cmp(32'(irq), 1);
    rd(`REG_STATUS, 32'h1);
    @(posedge clock);
    cmp(32'(irq), 0);
    chk("StAtUs", 1, 1, RPY_STATUS, 7, 1, 0, 0);
  endtask
  task automatic t_query();
    chk("error?", 1, 1, RPY_QUERY, 5, 0, 0, 0);
    chk("Error=Off", 1, 1, RPY_OK, 2, 0, 0, 1);
    cmp(32'(nvmData), 32'h1);
    chk("ERROR?", 1, 1, RPY_QUERY, 5, 1, 0, 0);
    chk(s30, 1, 0, RPY_UNKNOWN, 0, 0, 0, 0);
    chk("error=on", 1, 1, RPY_OK, 1, 0, 0, 1);
    chk(s30, 1, 1, RPY_UNKNOWN, 0, 0, 0, 0);
    chk({s30, "A"}, 1, 0, RPY_UNKNOWN, 0, 0, 0, 0);
    wb(1'b0, `REG_STATUS, 32'h0);
    cmp(q & 32'hC, 32'hC);
  endtask
  task automatic t_pass();
    wb(1'b1, `REG_PWLEN, 32'h2);
    wb(1'b1, `REG_PW0, 32'h3937);
    chk("79status", 1, 1, RPY_STATUS, 7, 1, 0, 0);
    chk("status", 1, 0, RPY_STATUS, 7, 1, 0, 0);
    chk("97STATUS", 1, 0, RPY_STATUS, 7, 1, 0, 0);
    wb(1'b1, `REG_PWLEN, 32'h0);
    wb(1'b1, `REG_CTRL, 32'h2);
    chk("status", 1, 0, RPY_STATUS, 7, 1, 0, 0);
    chk("nonsense", 1, 1, RPY_UNKNOWN, 0, 0, 0, 0);
    wb(1'b1, `REG_CTRL, 32'h3);
  endtask
  task automatic t_owner();
    chk(ownerLow, 0, 1, RPY_OK, 0, 0, 0, 0);
    chk(string'(`CMD_TXT_OWNER), 1, 1, RPY_OK, 0, 0, 1, 1);
    cmp(32'(nvmData), 32'h7);
  endtask
  task automatic t_window();
    repeat (1900) @(posedge clock);
    chk("reply=on", 1, 1, RPY_OK, 3, 0, 0, 1);
    repeat (1900) @(posedge clock);
    chk("status", 1, 1, RPY_STATUS, 7, 3, 0, 0);
    repeat (150) @(posedge clock);
    chk("error=off", 1, 1, RPY_EXPIRED, 2, 0, 0, 0);
    chk("reply?", 1, 1, RPY_QUERY, 6, 0, 0, 0);
    chk("status", 1, 1, RPY_STATUS, 7, 2, 0, 0);
    wb(1'b1, `REG_CTRL, 32'h5);
    chk("error=off", 1, 0, RPY_EXPIRED, 2, 0, 0, 0);
  endtask
  task automatic t_reload();
    arst_n <= 1'b0;
    nvmValid <= 1'b1;
    nvmLoadData <= 3'h6;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd(`REG_CTRL, 32'h6);
    wb(1'b0, `REG_STATE, 32'h0);
    cmp(q & 32'hD, 32'hD);
  endtask
  initial begin
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = 32'h0;
    nvmValid = 1'b0;
    nvmLoadData = 3'h0;
    startupOk = 1'b1;
    netRegistered = 1'b0;
    simPinRequired = 1'b0;
    s30 = "";
    repeat (30) s30 = {s30, "A"};
    ownerLow = string'(`CMD_TXT_OWNER | 80'h20202020202020202020);
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    t_leds();
    t_regs();
    t_query();
    t_pass();
    t_owner();
    t_window();
    t_reload();
    summarize();
  end
endmodule
`default_nettype wire
